/* File: rtl/codec_clock_pkg.sv */
// Purpose : types shared by the clock block and its users
// Assumes : nothing beyond the register header
// Notes   : constants live in codec_clock_regs.svh
package codec_clock_pkg;

  typedef struct packed {
    logic [15:0] denominator;
    logic [15:0] numerator;
    logic [3:0]  multiplier;
    logic [2:0]  input_divide_ratio;
    logic        fractional;
  } pll_setup_t;

  typedef enum logic [0:0] {
    bus_idle,
    bus_answer
  } bus_state_t;

endpackage : codec_clock_pkg

/* File: rtl/codec_clock_pll_config.sv */
// Purpose : clock control, pll setup registers and clock output selector of the codec
// Assumes : master clock pins are asynchronous to aclk and far slower than 20 MHz
// Notes   : axi4-lite slave, one write and one read at a time, byte data in bits 7:0
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "codec_clock_regs.svh"

// Notes on behaviour
// - with main clock gate low only clock control, pll and clock output select registers take writes
// - main clock gate also enables the pll clock output
// - with main clock gate set, parameter writes are rejected while the dsp clock enable is low
// - 16-bit pll denominator, high byte index 1, low byte index 2, reset zero
// - 16-bit pll numerator, high byte index 3, low byte index 4, reset zero
// - multiplier in bits 6:3 codes 2 to 8; bit 0 picks integer or fractional
// - pre-divider bits 2:1 divide the pin clock by field plus one
// - lock status bit 0 is read-only, one when locked, resets to zero
// - rate select: x2, x1, half, quarter, eighth, and 111 held low
// - x1 and x2 output settings do not work while density output is on
// - the chosen clock reaches the shared pin only in clock-output mode
// - output clock is the x2 pin clock, the master clock, or the master clock divided by 2, 4 or 8
// - pll runs only when pll enable and main clock gate are both one
module codec_clock_pll_config
  import codec_clock_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  master_clock_in,
  input  wire logic                  master_clock_x2_in,
  input  wire logic                  pll_lock_in,
  output      pll_setup_t            pll_setup,
  output      logic                  pll_setup_valid,
  output      logic                  pll_power_on,
  output      logic                  main_clock_gate,
  output      logic                  main_source_select,
  output      logic                  master_divide_one,
  output      logic                  core_divide_one,
  output      logic                  dsp_clock_enable,
  output      logic [1:0]            density_output_config,
  output      logic [7:0]            processing_parameter,
  output      logic                  shared_output_pin,
  output      logic                  shared_pin_clock_mode,
  output      logic                  irq
);

  // refused at elaboration: the index is taken from address bits 9:2
  // and a narrower bus could not reach the upper registers
  if (ADDR_WIDTH < 10) begin : g_width_check
    $error("ADDR_WIDTH too small for the register map");
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx <= `IDX_LAST_CLOCK_REG) || (idx == `IDX_SYSTEM_CONFIG) ||
                (idx == `IDX_PROCESSING_PARAMETER) || (idx == `IDX_IRQ_STATUS) ||
                (idx == `IDX_IRQ_MASK);
  endfunction : is_mapped

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0]  clock_enable_control;
  logic [7:0]  pll_denominator_high;
  logic [7:0]  pll_denominator_low;
  logic [7:0]  pll_numerator_high;
  logic [7:0]  pll_numerator_low;
  logic [7:0]  pll_integer_config;
  logic [7:0]  clock_output_select;
  logic [7:0]  system_config;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic        lock_meta;
  logic        lock_sync;
  logic        lock_prev;
  logic [2:1]  mclk_meta;
  logic [2:1]  mclk_sync;
  logic        mclk_prev;
  logic [2:0]  div_count;
  bus_state_t  wr_state;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  wr_idx;
  logic [7:0]  wr_byte;
  logic        wr_lane;

  // ------------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------------
  logic        do_write;
  logic        wr_ok;
  logic        wr_rejected;
  logic        gate_on;
  logic        clock_side_reg;

  assign gate_on        = clock_enable_control[`BIT_MAIN_CLOCK_GATE];
  assign do_write       = aw_held && w_held && (wr_state == bus_idle);
  assign clock_side_reg = (wr_idx <= `IDX_LAST_CLOCK_REG);
  // parameter writes need both the main clock and the dsp clock running
  assign wr_rejected    = do_write && is_mapped(wr_idx) &&
                          ((!gate_on && !clock_side_reg) ||
                           (gate_on && !system_config[`BIT_DSP_CLOCK_ENABLE] &&
                            wr_idx == `IDX_PROCESSING_PARAMETER));
  assign wr_ok          = do_write && is_mapped(wr_idx) && !wr_rejected && wr_lane;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b0;
      wr_idx        <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b1;
      wr_idx        <= reg_index(s_axi_awaddr);
    end else if (do_write) begin
      aw_held       <= 1'b0;
    end else if (!aw_held && wr_state == bus_idle) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b0;
      wr_byte      <= `RESET_BYTE;
      wr_lane      <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b1;
      wr_byte      <= s_axi_wdata[7:0];
      wr_lane      <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held       <= 1'b0;
    end else if (!w_held && wr_state == bus_idle) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state     <= bus_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      case (wr_state)
        bus_idle: begin
          if (do_write) begin
            wr_state     <= bus_answer;
            s_axi_bvalid <= 1'b1;
            // a gated write still answers okay
            s_axi_bresp  <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        bus_answer: begin
          if (s_axi_bready) begin
            wr_state     <= bus_idle;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state <= bus_idle;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_enable_control <= `RESET_BYTE;
      pll_denominator_high <= `RESET_BYTE;
      pll_denominator_low  <= `RESET_BYTE;
      pll_numerator_high   <= `RESET_BYTE;
      pll_numerator_low    <= `RESET_BYTE;
      pll_integer_config   <= `RESET_BYTE;
      clock_output_select  <= `RESET_BYTE;
      system_config        <= `RESET_BYTE;
      processing_parameter <= `RESET_BYTE;
      irq_mask             <= 3'h0;
    end else if (wr_ok) begin
      if (wr_idx == `IDX_CLOCK_ENABLE_CONTROL) begin
        clock_enable_control <= wr_byte;
      end else if (wr_idx == `IDX_PLL_DENOMINATOR_HIGH) begin
        pll_denominator_high <= wr_byte;
      end else if (wr_idx == `IDX_PLL_DENOMINATOR_LOW) begin
        pll_denominator_low  <= wr_byte;
      end else if (wr_idx == `IDX_PLL_NUMERATOR_HIGH) begin
        pll_numerator_high   <= wr_byte;
      end else if (wr_idx == `IDX_PLL_NUMERATOR_LOW) begin
        pll_numerator_low    <= wr_byte;
      end else if (wr_idx == `IDX_PLL_INTEGER_CONFIG) begin
        pll_integer_config   <= {1'b0, wr_byte[6:0]};
      end else if (wr_idx == `IDX_CLOCK_OUTPUT_SELECT) begin
        clock_output_select  <= {5'h00, wr_byte[`MSB_RATE_SELECT:0]};
      end else if (wr_idx == `IDX_SYSTEM_CONFIG) begin
        system_config        <= {4'h0, wr_byte[3:0]};
      end else if (wr_idx == `IDX_PROCESSING_PARAMETER) begin
        processing_parameter <= wr_byte;
      end else if (wr_idx == `IDX_IRQ_MASK) begin
        irq_mask             <= wr_byte[2:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // lock flag and interrupts
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      lock_meta <= pll_lock_in;
      lock_sync <= lock_meta;
      lock_prev <= lock_sync;
    end
  end

  logic [2:0] irq_events;
  logic [2:0] irq_clear;

  assign irq_events = {wr_rejected, lock_prev && !lock_sync, lock_sync && !lock_prev};
  assign irq_clear  = (wr_ok && wr_idx == `IDX_IRQ_STATUS) ? wr_byte[2:0] : 3'h0;

  // an event in the clearing cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 3'h0;
      irq       <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      irq        <= |(((irq_status & ~irq_clear) | irq_events) & irq_mask);
    end
  end

  // ------------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [7:0] rd_idx;

  assign rd_idx = reg_index(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx == `IDX_CLOCK_ENABLE_CONTROL) begin
      rd_byte = clock_enable_control;
    end else if (rd_idx == `IDX_PLL_DENOMINATOR_HIGH) begin
      rd_byte = pll_denominator_high;
    end else if (rd_idx == `IDX_PLL_DENOMINATOR_LOW) begin
      rd_byte = pll_denominator_low;
    end else if (rd_idx == `IDX_PLL_NUMERATOR_HIGH) begin
      rd_byte = pll_numerator_high;
    end else if (rd_idx == `IDX_PLL_NUMERATOR_LOW) begin
      rd_byte = pll_numerator_low;
    end else if (rd_idx == `IDX_PLL_INTEGER_CONFIG) begin
      rd_byte = pll_integer_config;
    end else if (rd_idx == `IDX_PLL_SETTLED_STATUS) begin
      rd_byte = {7'h00, lock_sync};
    end else if (rd_idx == `IDX_CLOCK_OUTPUT_SELECT) begin
      rd_byte = clock_output_select;
    end else if (rd_idx == `IDX_SYSTEM_CONFIG) begin
      rd_byte = system_config;
    end else if (rd_idx == `IDX_PROCESSING_PARAMETER) begin
      rd_byte = processing_parameter;
    end else if (rd_idx == `IDX_IRQ_STATUS) begin
      rd_byte = {5'h00, irq_status};
    end else if (rd_idx == `IDX_IRQ_MASK) begin
      rd_byte = {5'h00, irq_mask};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // pll and clock control outputs
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_setup             <= '0;
      pll_setup_valid       <= 1'b0;
      pll_power_on          <= 1'b0;
      main_clock_gate       <= 1'b0;
      main_source_select    <= 1'b0;
      master_divide_one     <= 1'b0;
      core_divide_one       <= 1'b0;
      dsp_clock_enable      <= 1'b0;
      density_output_config <= 2'h0;
      shared_pin_clock_mode <= 1'b0;
    end else begin
      pll_setup.denominator <= {pll_denominator_high, pll_denominator_low};
      pll_setup.numerator   <= {pll_numerator_high, pll_numerator_low};
      pll_setup.multiplier  <= pll_integer_config[`MSB_MULTIPLIER:`LSB_MULTIPLIER];
      pll_setup.fractional  <= pll_integer_config[`BIT_PLL_TYPE];
      pll_setup.input_divide_ratio <=
        {1'b0, pll_integer_config[`MSB_PRE_DIVIDE:`LSB_PRE_DIVIDE]} + 3'h1;
      pll_setup_valid <=
        (pll_integer_config[`MSB_MULTIPLIER:`LSB_MULTIPLIER] >= `MULTIPLIER_MIN) &&
        (pll_integer_config[`MSB_MULTIPLIER:`LSB_MULTIPLIER] <= `MULTIPLIER_MAX);
      pll_power_on <= clock_enable_control[`BIT_PLL_ENABLE] && gate_on;
      main_clock_gate       <= gate_on;
      main_source_select    <= clock_enable_control[`BIT_MAIN_SOURCE_SELECT];
      master_divide_one     <= clock_enable_control[`BIT_CC_MDIV];
      core_divide_one       <= clock_enable_control[`BIT_CC_SDIV];
      dsp_clock_enable      <= system_config[`BIT_DSP_CLOCK_ENABLE];
      density_output_config <= system_config[`MSB_DENSITY_OUTPUT:`LSB_DENSITY_OUTPUT];
      shared_pin_clock_mode <= system_config[`BIT_PIN_CLOCK_MODE];
    end
  end

  // ------------------------------------------------------------------
  // clock output generator
  // ------------------------------------------------------------------
  // the divided rates are built from sampled master clock edges, so jitter
  // of one aclk period is the price of staying in one clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mclk_meta <= 2'h0;
      mclk_sync <= 2'h0;
      mclk_prev <= 1'b0;
      div_count <= 3'h0;
    end else begin
      mclk_meta <= {master_clock_x2_in, master_clock_in};
      mclk_sync <= mclk_meta;
      mclk_prev <= mclk_sync[1];
      if (!gate_on) begin
        div_count <= 3'h0;
      end else if (mclk_sync[1] && !mclk_prev) begin
        div_count <= div_count + 3'h1;
      end
    end
  end

  logic [2:0] rate_sel;
  logic       rate_clock;

  assign rate_sel = clock_output_select[`MSB_RATE_SELECT:0];

  always_comb begin
    rate_clock = 1'b0;
    case (rate_sel)
      `RATE_X2:   rate_clock = mclk_sync[2];
      `RATE_X1:   rate_clock = mclk_sync[1];
      `RATE_DIV2: rate_clock = div_count[0];
      `RATE_DIV4: rate_clock = div_count[1];
      `RATE_DIV8: rate_clock = div_count[2];
      default:    rate_clock = 1'b0;
    endcase
    if (density_output_config != 2'h0 && (rate_sel == `RATE_X2 || rate_sel == `RATE_X1)) begin
      rate_clock = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_output_pin <= 1'b0;
    end else begin
      shared_output_pin <= rate_clock && gate_on &&
                           system_config[`BIT_PIN_CLOCK_MODE];
    end
  end

endmodule : codec_clock_pll_config

/* File: rtl/codec_clock_regs.svh */
// Purpose : register map, field positions, reset values and codes of the clock block
// Assumes : byte address of a register is four times its index
// Notes   : definitions only
`ifndef CODEC_CLOCK_REGS_SVH
`define CODEC_CLOCK_REGS_SVH

// ------------------------------------------------------------------
// register indices
// ------------------------------------------------------------------
`define IDX_CLOCK_ENABLE_CONTROL  8'h00
`define IDX_PLL_DENOMINATOR_HIGH  8'h01
`define IDX_PLL_DENOMINATOR_LOW   8'h02
`define IDX_PLL_NUMERATOR_HIGH    8'h03
`define IDX_PLL_NUMERATOR_LOW     8'h04
`define IDX_PLL_INTEGER_CONFIG    8'h05
`define IDX_PLL_SETTLED_STATUS    8'h06
`define IDX_CLOCK_OUTPUT_SELECT   8'h07
`define IDX_SYSTEM_CONFIG         8'h10
`define IDX_PROCESSING_PARAMETER  8'h11
`define IDX_IRQ_STATUS            8'h12
`define IDX_IRQ_MASK              8'h13
`define IDX_LAST_CLOCK_REG        8'h07

// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define BIT_MAIN_CLOCK_GATE       0
`define BIT_CC_MDIV               1
`define BIT_CC_SDIV               2
`define BIT_MAIN_SOURCE_SELECT    3
`define BIT_PLL_ENABLE            7
`define BIT_PLL_TYPE              0
`define MSB_PRE_DIVIDE            2
`define LSB_PRE_DIVIDE            1
`define MSB_MULTIPLIER            6
`define LSB_MULTIPLIER            3
`define BIT_LOCK                  0
`define MSB_RATE_SELECT           2
`define BIT_DSP_CLOCK_ENABLE      0
`define MSB_DENSITY_OUTPUT        2
`define LSB_DENSITY_OUTPUT        1
`define BIT_PIN_CLOCK_MODE        3
`define BIT_IRQ_LOCK_GAINED       0
`define BIT_IRQ_LOCK_LOST         1
`define BIT_IRQ_WRITE_REJECTED    2

// ------------------------------------------------------------------
// values
// ------------------------------------------------------------------
`define RESET_BYTE                8'h00
`define MULTIPLIER_MIN            4'h2
`define MULTIPLIER_MAX            4'h8
`define RATE_X2                   3'h0
`define RATE_X1                   3'h1
`define RATE_DIV2                 3'h2
`define RATE_DIV4                 3'h3
`define RATE_DIV8                 3'h4
`define RATE_OFF                  3'h7
`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2

`endif

/* File: tb/codec_clock_pll_config_monitor.sv */
// Purpose : port checker of the clock block
// Assumes : one clock domain, synchronous active-low reset
// Notes   : bound to every instance of the block below the module
`timescale 1ns/10ps
module codec_clock_pll_config_monitor
  import codec_clock_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire pll_setup_t  pll_setup,
  input wire logic        pll_setup_valid,
  input wire logic        pll_power_on,
  input wire logic        main_clock_gate,
  input wire logic        dsp_clock_enable,
  input wire logic [7:0]  processing_parameter
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pll_needs_gate: assert property (pll_power_on |-> main_clock_gate)
    else $error("pll on with main gate low");
  a_setup_valid: assert property
    (pll_setup_valid == (pll_setup.multiplier inside {[4'h2:4'h8]}))
    else $error("setup valid disagrees with multiplier");
  // the setup output trails the registers, so give it three edges after reset
  a_divide_ratio: assert property
    ($past(aresetn, 3) |-> pll_setup.input_divide_ratio inside {[3'h1:3'h4]})
    else $error("divide ratio out of range");
  a_param_gated: assert property
    (!(main_clock_gate && dsp_clock_enable) [*2] |-> $stable(processing_parameter))
    else $error("parameter changed while writes are blocked");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_r_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_b_hold: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_resp_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
  c_pll_on: cover property (pll_power_on);
endmodule : codec_clock_pll_config_monitor

bind codec_clock_pll_config codec_clock_pll_config_monitor i_monitor (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pll_setup, .pll_setup_valid, .pll_power_on, .main_clock_gate,
  .dsp_clock_enable, .processing_parameter
);

/* File: tb/codec_clock_pll_config_test.sv */
// Purpose : self-checking bench of the clock block over axi4-lite
// Assumes : byte address is four times the register index
// Notes   : master clock pins run far slower than aclk, as the block expects
`timescale 1ns/10ps
module codec_clock_pll_config_test
  import codec_clock_pkg::*;
;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [2:0]  mc = 3'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, density_output_config;
  logic [7:0]  processing_parameter;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pll_lock_in = 1'h0;
  logic        master_clock_in = 1'h0, master_clock_x2_in = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        pll_setup_valid, pll_power_on, main_clock_gate, main_source_select, irq;
  logic        master_divide_one, core_divide_one, dsp_clock_enable;
  logic        shared_output_pin, shared_pin_clock_mode;
  pll_setup_t  pll_setup;
  int          n_fail = 0, n_tests = 0;

  codec_clock_pll_config i_dut (.*);

  initial forever #12.5 aclk = ~aclk;
  // slow master clock: x1 rises every 8 cycles, x2 every 4
  always @(posedge aclk) begin
    mc <= mc + 3'h1;
    master_clock_in <= mc[2];
    master_clock_x2_in <= mc[1];
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic limit(input int k);
    if (k >= 64) begin
      chk("handshake", 32'h1, 32'h0);
      close_out();
    end
  endtask : limit

  // each channel drops at its own taking edge; the answer is taken at the edge
  // where valid meets the ready held up since the request, then one edge passes
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int k;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    limit(k);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    int k;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    limit(k);
    chk("read", {er, 22'h0, ed}, {s_axi_rresp, s_axi_rdata[29:0]});
    @(posedge aclk);
  endtask : rd

  // counts rising edges on the pin; phase at the window start allows one either way
  task automatic edges(input logic [2:0] code, input int exp);
    int   n = 0;
    logic p = 1'h0;
    wr(8'h07, {5'h0, code}, 2'h0);
    repeat (16) @(posedge aclk);
    repeat (256) begin
      @(posedge aclk);
      if (shared_output_pin && !p) n++;
      p = shared_output_pin;
    end
    chk("pin edges", 32'h1, {31'h0, n >= exp - 1 && n <= exp + 1});
  endtask : edges

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(i[7:0], 8'h00, 2'h0);
    wr(8'h11, 8'h5a, 2'h0);
    wr(8'h10, 8'h09, 2'h0);
    rd(8'h11, 8'h00, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
    $display("test gated writes done");
    wr(8'h01, 8'hc3, 2'h0);
    wr(8'h02, 8'h5a, 2'h0);
    wr(8'h03, 8'h81, 2'h0);
    wr(8'h04, 8'h7e, 2'h0);
    rd(8'h01, 8'hc3, 2'h0);
    rd(8'h04, 8'h7e, 2'h0);
    chk("denominator", 32'hc35a, {16'h0, pll_setup.denominator});
    chk("numerator", 32'h817e, {16'h0, pll_setup.numerator});
    for (int m = 0; m < 10; m++) begin
      wr(8'h05, {1'h0, m[3:0], m[1:0], m[0]}, 2'h0);
      @(posedge aclk);
      chk("multiplier", m, {28'h0, pll_setup.multiplier});
      chk("ratio", m % 4 + 1, {29'h0, pll_setup.input_divide_ratio});
      chk("fractional", m % 2, {31'h0, pll_setup.fractional});
      chk("setup valid", m >= 2 && m <= 8, {31'h0, pll_setup_valid});
    end
    $display("test pll setup done");
    pll_lock_in <= 1'h1;
    repeat (4) @(posedge aclk);
    rd(8'h06, 8'h01, 2'h0);
    wr(8'h06, 8'h00, 2'h0);
    rd(8'h06, 8'h01, 2'h0);
    wr(8'h00, 8'h81, 2'h0);
    @(posedge aclk);
    chk("pll power", 32'h1, {31'h0, pll_power_on});
    wr(8'h00, 8'h80, 2'h0);
    @(posedge aclk);
    chk("pll power", 32'h0, {31'h0, pll_power_on});
    wr(8'h00, 8'h8b, 2'h0);
    chk("control outs", 32'he, {28'h0, main_clock_gate, main_source_select,
        master_divide_one, core_divide_one});
    wr(8'h11, 8'h5a, 2'h0);
    rd(8'h11, 8'h00, 2'h0);
    wr(8'h10, 8'h09, 2'h0);
    wr(8'h11, 8'h5a, 2'h0);
    rd(8'h11, 8'h5a, 2'h0);
    chk("parameter", 32'h5a, {24'h0, processing_parameter});
    $display("test enables done");
    rd(8'h12, 8'h05, 2'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h13, 8'h04, 2'h0);
    @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h12, 8'h04, 2'h0);
    @(posedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h12, 8'h01, 2'h0);
    wr(8'h20, 8'h11, 2'h2);
    rd(8'h20, 8'h00, 2'h2);
    pll_lock_in <= 1'h0;
    repeat (4) @(posedge aclk);
    rd(8'h06, 8'h00, 2'h0);
    rd(8'h12, 8'h03, 2'h0);
    $display("test interrupts done");
    for (int c = 0; c < 5; c++) edges(c[2:0], 64 >> c);
    edges(3'h7, 0);
    wr(8'h10, 8'h0b, 2'h0);
    chk("system outs", 32'h7, {28'h0, density_output_config,
        shared_pin_clock_mode, dsp_clock_enable});
    edges(3'h1, 0);
    edges(3'h0, 0);
    wr(8'h10, 8'h01, 2'h0);
    edges(3'h2, 0);
    $display("test clock output done");
    close_out();
  end
endmodule : codec_clock_pll_config_test
